// File: rtl/usart_pkg.sv
// Purpose: shared constants, types and register map of the serial transceiver
// Assumes: AHB-Lite word registers, one system clock
// Notes: bit positions below index the low byte of each register word
// What this block does
// RULE_01 - transmit and receive run independently with separate data registers
// RULE_02 - four clock modes: async normal, async double, sync master, sync slave
// RULE_03 - sync_select chooses asynchronous or synchronous operation for both directions
// RULE_04 - in sync mode pin direction picks internal master or external slave clock
// RULE_05 - double_speed acts only in asynchronous operation
// RULE_06 - transfer clock pin is used only in synchronous mode
// RULE_07 - slave transfer clock is synchronised before clocking transmitter or receiver
// RULE_08 - one transmit write buffer lets frames follow with no gap
// RULE_09 - two-entry circular receive FIFO, each data read consumes one entry
// RULE_10 - frame error, overrun and ninth bit stored with each word; read first
// RULE_11 - with FIFO full, finished word waits in shifter until next start bit
// RULE_12 - receiver reports frame error, overrun and parity error
// RULE_13 - clock and data recovery used for asynchronous reception only
// RULE_14 - 5 to 9 data bits, one or two stop bits, same for both directions
// RULE_15 - parity generated on transmit, checked on receive, odd or even
// RULE_16 - receive noise filter: low-pass majority vote and false start rejection
// RULE_17 - three interrupt sources: transmit complete, data empty, receive complete
// RULE_18 - clock generator, transmitter and receiver share one control register set
// RULE_19 - baud down-counter reloads at zero or on divisor write, ticks at zero
// RULE_20 - bit time is 2, 8 or 16 baud ticks depending on mode
// RULE_21 - external clock takes two system clocks through sync and edge detect; here it takes three
// RULE_22 - polarity clear: change on rising, sample on falling; set reverses
package usart_pkg;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CSA = 8'h04;
  localparam logic [7:0] OFS_CSB = 8'h08;
  localparam logic [7:0] OFS_CSC = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [7:0] OFS_DIR = 8'h14;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam int BAUD_W = 12;
  localparam logic [4:0] OVS_NORM = 5'h10;
  localparam logic [4:0] OVS_DBL = 5'h08;
  localparam logic [3:0] NB_BASE = 4'h5;
  localparam logic [3:0] NB_MAX = 4'h9;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] CSZ_RST = 2'h3;
  // ctrl_status_a bits
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_EMPTY = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_PE = 2;
  localparam int A_U2X = 1;
  // ctrl_status_b bits
  localparam int B_RXCIE = 7;
  localparam int B_TXCIE = 6;
  localparam int B_EIE = 5;
  localparam int B_RXEN = 4;
  localparam int B_TXEN = 3;
  localparam int B_SZ2 = 2;
  localparam int B_RX9 = 1;
  localparam int B_TX9 = 0;
  // ctrl_status_c bits
  localparam int C_SYNC = 6;
  localparam int C_PM = 4;
  localparam int C_STOP2 = 3;
  localparam int C_SZ = 1;
  localparam int C_POL = 0;
  localparam int D_DIR = 0;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic overrun_flag;
    logic pe;
  } rx_entry_s;

  typedef struct packed {
    logic u2x;
    logic rxcie;
    logic txcie;
    logic eie;
    logic rxen;
    logic txen;
    logic sz2;
    logic tx9;
    logic sync;
    logic [1:0] pm;
    logic stop2;
    logic [1:0] sz;
    logic pol;
    logic dir;
    logic [BAUD_W-1:0] baud;
  } cfg_s;

  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic tx_empty;
  } irq_s;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_e;

  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_START = 6'b000010,
    TX_DATA = 6'b000100,
    TX_PAR = 6'b001000,
    TX_STOP1 = 6'b010000,
    TX_STOP2 = 6'b100000
  } tx_state_e;

  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA = 6'b000100,
    RX_PAR = 6'b001000,
    RX_STOP = 6'b010000,
    RX_HOLD = 6'b100000
  } rx_state_e;
endpackage

// File: rtl/usart_core.sv
// Purpose: full-duplex serial transceiver with AHB-Lite register slave
// Assumes: single 10 MHz clock, synchronous active-low reset
// Notes: every bus access takes one wait state
`timescale 1ns/100ps
module usart_core
(
  input wire logic clk, // system clock
  input wire logic resetn, // sync reset, low active
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic rxd, // serial receive pin
  output logic txd, // serial transmit pin
  input wire logic xck_i, // transfer clock pin in
  output logic xck_o, // transfer clock pin out
  output logic xck_oe, // transfer clock drive enable
  output usart_pkg::irq_s irq // interrupt requests
);
  import usart_pkg::*;

  typedef struct packed {
    bus_state_e bst;
    logic wr;
    logic [7:0] adr;
    logic ok;
    logic [31:0] rdat;
    cfg_s cfg;
    logic [BAUD_W-1:0] bcnt;
    logic [2:0] rs;
    logic rf;
    logic [2:0] xs;
    logic xf;
    logic xo;
    tx_state_e tst;
    logic [8:0] tbuf;
    logic tfull;
    logic [8:0] tsh;
    logic [3:0] tbit;
    logic [4:0] tpre;
    logic tpar;
    logic txd;
    logic tdone;
    rx_state_e rst;
    logic [8:0] rsh;
    logic [3:0] rbit;
    logic [4:0] rpre;
    logic [2:0] maj;
    logic rpar;
    logic rfe;
    logic rpe;
    logic ovp;
    rx_entry_s [1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } st_s;

  st_s s_q;
  st_s s_d;
  rx_entry_s head;
  rx_entry_s ent;
  logic [31:0] rv;
  logic [4:0] ovs;
  logic [3:0] nb;
  logic take;
  logic wen;
  logic twr;
  logic bwr;
  logic pop;
  logic tick;
  logic master;
  logic rise;
  logic fall;
  logic chg;
  logic smp;
  logic tstep;
  logic fin;
  logic ld;
  logic rsmp;
  logic rval;
  logic strt;
  logic brx;
  logic psh;

  // data bits per frame from size code
  function automatic logic [3:0] nbits(input logic sz2, input logic [1:0] sz);
    nbits = sz2 ? NB_MAX : NB_BASE + {2'b00, sz};
  endfunction

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    head = s_q.fifo[s_q.rp];
    ent = '0;
    rv = '0;
    fin = 1'b0;
    ld = 1'b0;
    brx = 1'b0;
    psh = 1'b0;
    nb = nbits(s_q.cfg.sz2, s_q.cfg.sz); // RULE_14 RULE_18
    master = s_q.cfg.sync & s_q.cfg.dir; // RULE_02 RULE_04
    ovs = s_q.cfg.u2x ? OVS_DBL : OVS_NORM; // RULE_05 RULE_20
    tick = (s_q.bcnt == '0);

    // bus address phase capture and data phase
    take = hsel & htrans[1] & hready;
    unique case (s_q.bst)
      BUS_IDLE, BUS_DONE:
      begin
        s_d.bst = BUS_IDLE;
        if (take)
        begin
          s_d.bst = BUS_WAIT;
          s_d.wr = hwrite;
          s_d.adr = haddr[7:0];
          s_d.ok = (hsize == SIZE_WORD) & (haddr[31:8] == '0) & (haddr[1:0] == 2'h0);
        end
      end
      BUS_WAIT:
      begin
        s_d.bst = BUS_DONE;
      end
    endcase
    wen = (s_q.bst == BUS_WAIT) & s_q.wr & s_q.ok;
    twr = wen & (s_q.adr == OFS_DATA);
    bwr = wen & (s_q.adr == OFS_BAUD);
    pop = (s_q.bst == BUS_WAIT) & ~s_q.wr & s_q.ok & (s_q.adr == OFS_DATA) & (s_q.cnt != 2'h0);

    // register read mux, flags come from the FIFO head
    if ((s_q.bst == BUS_WAIT) & ~s_q.wr)
    begin
      if (s_q.ok)
      begin
        unique case (s_q.adr)
          OFS_DATA: rv[7:0] = head.data[7:0]; // RULE_01
          OFS_CSA:
          begin
            rv[A_RXC] = (s_q.cnt != 2'h0);
            rv[A_TXC] = s_q.tdone;
            rv[A_EMPTY] = ~s_q.tfull;
            rv[A_FE] = (s_q.cnt != 2'h0) & head.fe; // RULE_10 RULE_12
            rv[A_DOR] = (s_q.cnt != 2'h0) & head.overrun_flag;
            rv[A_PE] = (s_q.cnt != 2'h0) & head.pe;
            rv[A_U2X] = s_q.cfg.u2x;
          end
          OFS_CSB:
          begin
            rv[B_RXCIE] = s_q.cfg.rxcie;
            rv[B_TXCIE] = s_q.cfg.txcie;
            rv[B_EIE] = s_q.cfg.eie;
            rv[B_RXEN] = s_q.cfg.rxen;
            rv[B_TXEN] = s_q.cfg.txen;
            rv[B_SZ2] = s_q.cfg.sz2;
            rv[B_RX9] = (s_q.cnt != 2'h0) & head.data[8]; // RULE_10
            rv[B_TX9] = s_q.cfg.tx9;
          end
          OFS_CSC:
          begin
            rv[C_SYNC] = s_q.cfg.sync;
            rv[C_PM+1:C_PM] = s_q.cfg.pm;
            rv[C_STOP2] = s_q.cfg.stop2;
            rv[C_SZ+1:C_SZ] = s_q.cfg.sz;
            rv[C_POL] = s_q.cfg.pol;
          end
          OFS_BAUD: rv[BAUD_W-1:0] = s_q.cfg.baud;
          OFS_DIR: rv[D_DIR] = s_q.cfg.dir;
          default: rv = '0;
        endcase
      end
      s_d.rdat = rv;
    end

    // register writes, one shared set for all units
    if (wen)
    begin
      unique case (s_q.adr)
        OFS_CSA:
        begin
          s_d.cfg.u2x = hwdata[A_U2X];
          if (hwdata[A_TXC])
          begin
            s_d.tdone = 1'b0;
          end
        end
        OFS_CSB:
        begin
          s_d.cfg.rxcie = hwdata[B_RXCIE];
          s_d.cfg.txcie = hwdata[B_TXCIE];
          s_d.cfg.eie = hwdata[B_EIE];
          s_d.cfg.rxen = hwdata[B_RXEN];
          s_d.cfg.txen = hwdata[B_TXEN];
          s_d.cfg.sz2 = hwdata[B_SZ2];
          s_d.cfg.tx9 = hwdata[B_TX9];
        end
        OFS_CSC:
        begin
          s_d.cfg.sync = hwdata[C_SYNC]; // RULE_03
          s_d.cfg.pm = hwdata[C_PM+1:C_PM];
          s_d.cfg.stop2 = hwdata[C_STOP2];
          s_d.cfg.sz = hwdata[C_SZ+1:C_SZ];
          s_d.cfg.pol = hwdata[C_POL];
        end
        OFS_BAUD: s_d.cfg.baud = hwdata[BAUD_W-1:0];
        OFS_DIR: s_d.cfg.dir = hwdata[D_DIR];
        default: s_d.cfg = s_q.cfg;
      endcase
    end

    // baud down-counter
    s_d.bcnt = (tick | bwr) ? s_d.cfg.baud : s_q.bcnt - 1'b1; // RULE_19

    // three-stage pin synchronisers, filtered once stages 2 and 3 agree
    s_d.rs = {s_q.rs[1:0], rxd};
    if (s_q.rs[1] == s_q.rs[2])
    begin
      s_d.rf = s_q.rs[2];
    end
    s_d.xs = {s_q.xs[1:0], xck_i};
    if (s_q.xs[1] == s_q.xs[2])
    begin
      s_d.xf = s_q.xs[2]; // RULE_07 RULE_21
    end

    // transfer clock edges, master divides the tick by two
    s_d.xo = master ? (s_q.xo ^ tick) : 1'b0;
    if (master)
    begin
      rise = tick & ~s_q.xo; // RULE_04
      fall = tick & s_q.xo;
    end
    else
    begin
      rise = s_q.cfg.sync & (s_q.xs[1] == s_q.xs[2]) & s_q.xs[2] & ~s_q.xf; // RULE_07 RULE_21
      fall = s_q.cfg.sync & (s_q.xs[1] == s_q.xs[2]) & ~s_q.xs[2] & s_q.xf;
    end
    chg = s_q.cfg.pol ? fall : rise; // RULE_22
    smp = s_q.cfg.pol ? rise : fall; // RULE_22

    // transmitter bit timing
    if (tick)
    begin
      s_d.tpre = (s_q.tpre == ovs - 5'h1) ? 5'h0 : s_q.tpre + 5'h1; // RULE_20
    end
    tstep = s_q.cfg.sync ? chg : (tick & (s_q.tpre == ovs - 5'h1)); // RULE_03

    // transmitter frame sequencer
    if (tstep)
    begin
      unique case (s_q.tst)
        TX_IDLE: ld = s_q.tfull;
        TX_START:
        begin
          s_d.txd = s_q.tsh[0];
          s_d.tpar = s_q.tpar ^ s_q.tsh[0]; // RULE_15
          s_d.tsh = s_q.tsh >> 1;
          s_d.tbit = 4'h1;
          s_d.tst = TX_DATA;
        end
        TX_DATA:
        begin
          if (s_q.tbit == nb) // RULE_14
          begin
            s_d.txd = s_q.cfg.pm[1] ? s_q.tpar : 1'b1; // RULE_15
            s_d.tst = s_q.cfg.pm[1] ? TX_PAR : TX_STOP1;
          end
          else
          begin
            s_d.txd = s_q.tsh[0];
            s_d.tpar = s_q.tpar ^ s_q.tsh[0];
            s_d.tsh = s_q.tsh >> 1;
            s_d.tbit = s_q.tbit + 4'h1;
          end
        end
        TX_PAR:
        begin
          s_d.txd = 1'b1;
          s_d.tst = TX_STOP1;
        end
        TX_STOP1:
        begin
          if (s_q.cfg.stop2) // RULE_14
          begin
            s_d.tst = TX_STOP2;
          end
          else
          begin
            fin = 1'b1;
          end
        end
        TX_STOP2: fin = 1'b1;
      endcase
    end
    if (fin)
    begin
      ld = s_q.tfull; // RULE_08
      if (!s_q.tfull)
      begin
        s_d.tdone = 1'b1; // RULE_17
        s_d.tst = TX_IDLE;
      end
    end
    if (ld & s_q.cfg.txen)
    begin
      s_d.tsh = s_q.tbuf; // RULE_08
      s_d.tfull = 1'b0;
      s_d.txd = 1'b0;
      s_d.tpar = s_q.cfg.pm[0];
      s_d.tbit = 4'h0;
      s_d.tst = TX_START;
    end
    if (!s_q.cfg.txen)
    begin
      s_d.tst = TX_IDLE;
      s_d.txd = 1'b1;
    end
    if (twr)
    begin
      s_d.tbuf = {s_q.cfg.tx9, hwdata[7:0]}; // RULE_01 RULE_08
      s_d.tfull = 1'b1;
    end

    // receiver sample timing and majority filter
    if (tick)
    begin
      s_d.maj = {s_q.maj[1:0], s_q.rf}; // RULE_16
      s_d.rpre = (s_q.rpre == ovs - 5'h1) ? 5'h0 : s_q.rpre + 5'h1; // RULE_20
    end
    rsmp = s_q.cfg.sync ? smp : (tick & (s_q.rpre == (ovs >> 1))); // RULE_13
    rval = s_q.cfg.sync ? s_q.rf
      : ((s_q.maj[0] & s_q.maj[1]) | (s_q.maj[0] & s_q.maj[2]) | (s_q.maj[1] & s_q.maj[2])); // RULE_13 RULE_16
    strt = s_q.cfg.sync ? (smp & ~s_q.rf) : (tick & ~s_q.rf);

    // FIFO read side frees a slot first
    if (pop)
    begin
      s_d.rp = ~s_q.rp; // RULE_09
      s_d.cnt = s_q.cnt - 2'h1;
    end

    // receiver frame sequencer
    unique case (s_q.rst)
      RX_IDLE: brx = strt;
      RX_START:
      begin
        if (rsmp)
        begin
          s_d.rst = rval ? RX_IDLE : RX_DATA; // RULE_16
        end
      end
      RX_DATA:
      begin
        if (rsmp)
        begin
          s_d.rsh = {rval, s_q.rsh[8:1]};
          s_d.rpar = s_q.rpar ^ rval;
          s_d.rbit = s_q.rbit + 4'h1;
          if (s_q.rbit == nb - 4'h1) // RULE_14
          begin
            s_d.rst = s_q.cfg.pm[1] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR:
      begin
        if (rsmp)
        begin
          s_d.rpe = rval ^ s_q.rpar; // RULE_12 RULE_15
          s_d.rst = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (rsmp)
        begin
          s_d.rfe = ~rval; // RULE_12
          s_d.rsh = s_q.rsh >> (NB_MAX - nb);
          psh = 1'b1;
        end
      end
      RX_HOLD:
      begin
        psh = 1'b1;
        if ((s_d.cnt == FIFO_FULL) & strt)
        begin
          psh = 1'b0; // RULE_11
          s_d.ovp = 1'b1; // RULE_12
          brx = 1'b1;
        end
      end
    endcase

    // store word with its flags, else keep it in the shifter
    ent = '{data: s_d.rsh, fe: s_d.rfe, overrun_flag: s_q.ovp, pe: s_d.rpe}; // RULE_10
    if (psh)
    begin
      if (s_d.cnt != FIFO_FULL)
      begin
        s_d.fifo[s_q.wp] = ent; // RULE_09
        s_d.wp = ~s_q.wp;
        s_d.cnt = s_d.cnt + 2'h1;
        s_d.ovp = 1'b0;
        s_d.rst = RX_IDLE;
      end
      else
      begin
        s_d.rst = RX_HOLD; // RULE_11
      end
    end
    if (brx)
    begin
      s_d.rpe = 1'b0;
      s_d.rfe = 1'b0;
      s_d.rbit = 4'h0;
      s_d.rpar = s_q.cfg.pm[0];
      s_d.rpre = 5'h0;
      s_d.rst = s_q.cfg.sync ? RX_DATA : RX_START; // RULE_13
    end
    if (!s_q.cfg.rxen)
    begin
      s_d.rst = RX_IDLE;
      s_d.cnt = 2'h0;
      s_d.rp = s_q.wp;
      s_d.ovp = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.bst <= BUS_IDLE;
      s_q.tst <= TX_IDLE;
      s_q.rst <= RX_IDLE;
      s_q.txd <= 1'b1;
      s_q.rs <= '1;
      s_q.rf <= 1'b1;
      s_q.maj <= '1;
      s_q.cfg.sz <= CSZ_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign hrdata = s_q.rdat;
  assign hreadyout = (s_q.bst != BUS_WAIT);
  assign hresp = 1'b0;
  assign txd = s_q.txd; // RULE_01
  assign xck_o = s_q.xo;
  assign xck_oe = master; // RULE_06
  assign irq.rx_done = s_q.cfg.rxcie & (s_q.cnt != 2'h0); // RULE_17
  assign irq.tx_done = s_q.cfg.txcie & s_q.tdone; // RULE_17
  assign irq.tx_empty = s_q.cfg.eie & ~s_q.tfull; // RULE_17
endmodule

// File: tb/usart_checker.sv
// Purpose: port-level assertions for the serial transceiver
// Assumes: one clock, synchronous active-low reset
// Notes: mode bits are followed from register writes on the bus
`timescale 1ns/100ps
module usart_checker
(
  input wire logic clk, // system clock
  input wire logic resetn, // reset, low active
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic txd, // serial out
  input wire logic xck_o, // clock pin value
  input wire logic xck_oe, // clock pin enable
  input wire usart_pkg::irq_s irq // requests
);
  import usart_pkg::*;
  logic wr_q;
  logic [7:0] wa_q;
  logic sync_q;
  logic dir_q;
  logic pol_q;

  // follow writes to the mode and pin direction registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      sync_q <= 1'b0;
      dir_q <= 1'b0;
      pol_q <= 1'b0;
    end
    else if (wr_q && !hreadyout)
    begin
      wr_q <= 1'b0;
      if (wa_q == OFS_CSC)
      begin
        sync_q <= hwdata[C_SYNC];
        pol_q <= hwdata[C_POL];
      end
      if (wa_q == OFS_DIR)
        dir_q <= hwdata[D_DIR];
    end
    else if (hsel && htrans[1] && hready)
    begin
      wr_q <= hwrite;
      wa_q <= haddr[7:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // bus protocol and register data
  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("access did not take one wait state");
  chk_data_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside a transfer");
  // transfer clock pin use
  chk_xck_drive: assert property ((sync_q && dir_q) [*2] |-> xck_oe)
    else $error("master mode not driving clock pin");
  chk_xck_off: assert property (!(sync_q && dir_q) [*2] |-> !xck_oe)
    else $error("clock pin driven outside master mode");
  chk_xck_still: assert property (!sync_q [*3] |-> $stable(xck_o))
    else $error("clock pin moved in asynchronous mode");
  chk_sync_edge: assert property (sync_q && dir_q && !pol_q && $changed(txd) |-> $rose(xck_o))
    else $error("sync data changed off the rising clock");
  // idle state after reset
  chk_reset_idle: assert property ($rose(resetn) |-> txd && !xck_oe && irq == '0)
    else $error("outputs not idle after reset");
  // no asynchronous bit is shorter than eight clocks
  chk_low_len: assert property (!sync_q && $fell(txd) |-> !txd [*8])
    else $error("low bit too short");
  chk_high_len: assert property (!sync_q && $rose(txd) |-> txd [*8])
    else $error("high bit too short");
endmodule

// File: tb/serial_partner.sv
// Purpose: remote serial device on the far side of the line pins
// Assumes: asynchronous 8-bit frames, bit time given in ns
// Notes: the transfer clock is never driven and rests low
`timescale 1ns/100ps
module serial_partner
(
  input wire logic txd, // line from the block
  input wire logic [15:0] bit_ns, // bit time in ns
  output logic rxd, // line into the block
  output logic transfer_clock_pin, // transfer clock, resting
  output logic got, // pulse per caught frame
  output logic [8:0] got_data // stop bit and data
);
  integer i;

  // idle line high, clock still outside frames
  initial
  begin
    rxd = 1'b1;
    transfer_clock_pin = 1'b0;
    got = 1'b0;
    got_data = '0;
  end

  // catch a frame at mid-bit, lsb first, stop bit last
  always
  begin
    @(negedge txd);
    #(bit_ns / 2);
    for (i = 0; i < 9; i++)
    begin
      #(bit_ns);
      got_data[i] = txd;
    end
    got = 1'b1;
    #1 got = 1'b0;
  end

  // send one frame: start, data, optional parity, stop, one idle bit
  task automatic send(input logic [7:0] d, input logic bad, input logic [1:0] par);
    #7; // keep line changes off the clock edge
    rxd = 1'b0;
    #(bit_ns);
    for (int k = 0; k < 8; k++)
    begin
      rxd = d[k];
      #(bit_ns);
    end
    if (par[1])
    begin
      rxd = ^d ^ par[0];
      #(bit_ns);
    end
    rxd = ~bad;
    #(bit_ns);
    rxd = 1'b1;
    #(bit_ns);
  endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the serial transceiver
// Assumes: word registers over AHB-Lite, 10 MHz clock
// Notes: frames sent are queued and checked as the remote catches them
`timescale 1ns/100ps
module tb;
  import usart_pkg::*;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, rxd, txd, xck_i, xck_o, xck_oe, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv, seed;
  logic [8:0] got_data;
  logic [15:0] bit_ns;
  logic [7:0] v [0:3];
  logic [8:0] exp_q [$];
  irq_s irq;
  int mismatches, n_tests, k, p;

  usart_core i_dut
  (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd(rxd), .txd(txd), .xck_i(xck_i), .xck_o(xck_o), .xck_oe(xck_oe), .irq(irq)
  );

  serial_partner i_far
  (
    .txd(txd), .bit_ns(bit_ns), .rxd(rxd), .transfer_clock_pin(xck_i), .got(got), .got_data(got_data)
  );

  // 100 ns clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one word transfer: address phase, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rv = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(rv & m, want);
  endtask

  // remote sends n random bytes back to back
  task automatic burst(input int n, input logic [1:0] par, input logic bad);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      v[i] = seed[7:0];
      i_far.send(v[i], bad, par);
    end
  endtask

  // wait for an empty write buffer, then queue the byte and write it
  task automatic tx(input logic [7:0] b);
    rv = 32'h0;
    for (int w = 0; w < 200 && rv[A_EMPTY] !== 1'b1; w++)
      bus(1'b0, OFS_CSA, 32'h0);
    exp_q.push_back({1'b1, b});
    bus(1'b1, OFS_DATA, {24'h0, b});
  endtask

  task automatic drain;
    for (k = 0; k < 3000 && exp_q.size() != 0; k++)
      @(posedge clk);
    check(32'(exp_q.size()), 32'h0);
    repeat (16) @(posedge clk);
  endtask

  // compare each caught frame with the oldest note
  always @(posedge got)
    if (exp_q.size() == 0)
      check(32'h1, 32'h0);
    else
      check({23'h0, got_data}, {23'h0, exp_q.pop_front()});

  // watchdog
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  // main sequence
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 32'h82d5;
    bit_ns = 16'd1600;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(OFS_CSA, 32'hff, 32'h20);
    rd_chk(OFS_CSC, 32'hff, 32'h06);
    rd_chk(8'h18, 32'hffffffff, 32'h0);
    bus(1'b1, OFS_BAUD, 32'h0);
    bus(1'b1, OFS_CSB, 32'hf8);
    seed = lfsr(seed);
    // two frames out back to back while three come in
    fork
      burst(3, 2'b00, 1'b0);
      begin
        tx(seed[15:8]);
        tx(seed[23:16]);
      end
    join
    drain;
    check({29'h0, irq}, 32'h7);
    rd_chk(OFS_CSA, 32'h60, 32'h60);
    rd_chk(OFS_CSA, 32'h9c, 32'h80);
    for (p = 0; p < 3; p++)
      rd_chk(OFS_DATA, 32'hff, {24'h0, v[p]});
    rd_chk(OFS_CSA, 32'h80, 32'h0);
    check({29'h0, irq}, 32'h3);
    // fourth word overruns the held one
    burst(4, 2'b00, 1'b0);
    rd_chk(OFS_DATA, 32'hff, {24'h0, v[0]});
    rd_chk(OFS_DATA, 32'hff, {24'h0, v[1]});
    rd_chk(OFS_CSA, 32'h08, 32'h08);
    rd_chk(OFS_DATA, 32'hff, {24'h0, v[3]});
    // even parity, good then bad, then a broken stop bit
    bus(1'b1, OFS_CSC, 32'h26);
    for (p = 0; p < 2; p++)
    begin
      burst(1, {1'b1, p[0]}, 1'b0);
      rd_chk(OFS_CSA, 32'h04, {29'h0, p[0], 2'h0});
      rd_chk(OFS_DATA, 32'hff, {24'h0, v[0]});
    end
    burst(1, 2'b10, 1'b1);
    rd_chk(OFS_CSA, 32'h10, 32'h10);
    rd_chk(OFS_DATA, 32'hff, {24'h0, v[0]});
    // double speed halves the bit time
    bus(1'b1, OFS_CSA, 32'h02);
    bit_ns = 16'd800;
    seed = lfsr(seed);
    tx(seed[7:0]);
    drain;
    // synchronous master: clock half period is divisor plus one
    bus(1'b1, OFS_BAUD, 32'h3);
    bus(1'b1, OFS_DIR, 32'h1);
    bus(1'b1, OFS_CSC, 32'h46);
    for (p = 0; p < 2; p++)
    begin
      rv[0] = xck_o;
      for (k = 0; k < 40 && xck_o === rv[0]; k++)
        @(posedge clk);
    end
    check(32'(k), 32'h4);
    // synchronous master frame, bit time two clock half periods
    bit_ns = 16'd800;
    tx(seed[15:8]);
    drain;
    complete_run;
  end
endmodule

bind usart_core usart_checker i_chk
(
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .txd(txd), .xck_o(xck_o), .xck_oe(xck_oe), .irq(irq)
);
